// ---- verilog/ups_map.vh ----
// Register offsets, bit positions and reset values for the USB power/suspend control block
`ifndef UPS_MAP_VH
`define UPS_MAP_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UPS_OFF_POWER_CONTROL   4'h0
`define UPS_OFF_IRQ_STATUS      4'h4
`define UPS_OFF_IRQ_MASK        4'h8
// ----------------------------------------------------------------
// Field positions in usb_power_control
// ----------------------------------------------------------------
`define UPS_BIT_OPERATION_ENABLE 0
`define UPS_BIT_SUSPEND_REQUEST  1
`define UPS_BIT_MODULE_NOT_READY 3
`define UPS_BIT_SLEEP_GUARD      4
`define UPS_BIT_ACTIVITY_PENDING 7
`define UPS_CTRL_WR_MASK         8'h13
// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define UPS_IRQ_ACTIVITY         0
`define UPS_IRQ_READY            1
`define UPS_IRQ_WIDTH            2
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define UPS_CTRL_RESET           8'h00
`define UPS_IRQ_RESET            2'h0
`define UPS_SETTLE_NS            1000
`define UPS_CLK_NS               10
`define UPS_SETTLE_CYCLES        ((`UPS_SETTLE_NS + `UPS_CLK_NS - 1) / `UPS_CLK_NS)
// ----------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------
`define UPS_RESP_OKAY            2'h0
`define UPS_RESP_SLVERR          2'h2
`endif

// ---- verilog/ups_sync2.v ----
// Two-flip-flop synchroniser for a single level
`timescale 1ns/1ns
module ups_sync2 (
    input  wire clk,
    input  wire srst,
    input  wire d,
    output wire q
);
    reg stage1;
    reg stage2;
    always @(posedge clk) begin
        if (srst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= d;
            stage2 <= stage1;
        end
    end
    assign q = stage2;
endmodule // ups_sync2

// ---- verilog/ups_power_ctrl.v ----
// USB power, suspend and sleep-guard control with AXI4-Lite registers
// Function
// R1: Pending flag set by activity, cleared when notified
// R2: Guard set blocks sleep on activity or pending
// R3: Not-ready high while active or settling
// R4: Suspend gates 48 MHz clock, transceiver low-power
// R5: Enable off holds outputs idle, pins released
// R6: Software avoids module registers while not ready
// R7: Unimplemented control bits read zero
// R8: Control bits clear at reset
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`include "ups_map.vh"
module ups_power_ctrl #(
    parameter SETTLE_CYCLES = `UPS_SETTLE_CYCLES
) (
    input  wire        clk,
    input  wire        srst,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        bus_activity,
    input  wire        notify_done,
    input  wire        module_active,
    input  wire        sleep_request,
    output wire        sleep_block,
    output reg         usb_clk_enable,
    output reg         xcvr_low_power,
    output reg         module_outputs_enable,
    output reg         pins_owned,
    output reg         analog_enable,
    output wire        irq
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg                        operation_enable;
    reg                        suspend_request;
    reg                        sleep_entry_guard;
    reg                        bus_activity_pending;
    reg  [15:0]                settle_count;
    reg  [`UPS_IRQ_WIDTH-1:0]  irq_status;
    reg  [`UPS_IRQ_WIDTH-1:0]  irq_mask;
    reg                        aw_held;
    reg                        w_held;
    reg  [3:0]                 aw_addr;
    reg  [31:0]                w_data;
    reg  [3:0]                 w_strb;
    reg                        prev_not_ready;
    wire                       activity_sync;
    wire                       module_not_ready;
    wire                       activity_seen;
    wire                       do_write;
    wire [7:0]                 ctrl_read;
    wire [`UPS_IRQ_WIDTH-1:0]  irq_events;
    wire [`UPS_IRQ_WIDTH-1:0]  irq_clear;

    // Bus activity comes from the transceiver pins, another domain
    ups_sync2 u_act_sync (
        .clk  (clk),
        .srst (srst),
        .d    (bus_activity),
        .q    (activity_sync)
    );
    assign activity_seen = activity_sync & operation_enable;

    // ----------------------------------------------------------------
    // Register read view
    // ----------------------------------------------------------------
    function [31:0] ups_read_word;
        input [3:0] addr;
        input [7:0] ctrl;
        input [`UPS_IRQ_WIDTH-1:0] stat;
        input [`UPS_IRQ_WIDTH-1:0] mask;
        begin
            case (addr)
                `UPS_OFF_POWER_CONTROL: ups_read_word = {24'h000000, ctrl}; // R7
                `UPS_OFF_IRQ_STATUS:    ups_read_word = {30'h00000000, stat};
                `UPS_OFF_IRQ_MASK:      ups_read_word = {30'h00000000, mask};
                default:                ups_read_word = 32'h00000000;
            endcase
        end
    endfunction

    function ups_addr_ok;
        input [3:0] addr;
        begin
            ups_addr_ok = (addr == `UPS_OFF_POWER_CONTROL) ||
                          (addr == `UPS_OFF_IRQ_STATUS) ||
                          (addr == `UPS_OFF_IRQ_MASK);
        end
    endfunction

    // Bits 6:5 and 2 are tied low
    assign ctrl_read = {bus_activity_pending, 2'b00, sleep_entry_guard,
                        module_not_ready, 1'b0, suspend_request,
                        operation_enable}; // R7

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign do_write      = aw_held & w_held & ~s_axi_bvalid;

    always @(posedge clk) begin
        if (srst) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 4'h0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `UPS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= ups_addr_ok(aw_addr) ? `UPS_RESP_OKAY : `UPS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `UPS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= ups_read_word(s_axi_araddr, ctrl_read, irq_status, irq_mask);
            s_axi_rresp  <= ups_addr_ok(s_axi_araddr) ? `UPS_RESP_OKAY : `UPS_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            operation_enable  <= 1'b0; // R8
            suspend_request   <= 1'b0; // R8
            sleep_entry_guard <= 1'b0; // R8
        end else if (do_write && aw_addr == `UPS_OFF_POWER_CONTROL && w_strb[0]) begin
            operation_enable  <= w_data[`UPS_BIT_OPERATION_ENABLE];
            suspend_request   <= w_data[`UPS_BIT_SUSPEND_REQUEST];
            sleep_entry_guard <= w_data[`UPS_BIT_SLEEP_GUARD];
        end
    end

    // ----------------------------------------------------------------
    // Activity pending and readiness
    // ----------------------------------------------------------------
    // Set wins over clear so an edge during notification is not lost
    always @(posedge clk) begin
        if (srst) begin
            bus_activity_pending <= 1'b0; // R8
        end else if (activity_seen) begin
            bus_activity_pending <= 1'b1; // R1
        end else if (notify_done) begin
            bus_activity_pending <= 1'b0; // R1
        end
    end

    // Settle time after disable before the module may be re-enabled
    always @(posedge clk) begin
        if (srst) begin
            settle_count <= 16'h0000;
        end else if (operation_enable || module_active) begin
            settle_count <= SETTLE_CYCLES[15:0];
        end else if (settle_count != 16'h0000) begin
            settle_count <= settle_count - 16'h0001;
        end
    end
    assign module_not_ready = operation_enable | module_active |
                              (settle_count != 16'h0000); // R3

    assign sleep_block = sleep_request & sleep_entry_guard &
                         (activity_sync | bus_activity_pending); // R2

    // ----------------------------------------------------------------
    // Power and clock outputs
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            usb_clk_enable        <= 1'b0;
            xcvr_low_power        <= 1'b1;
            module_outputs_enable <= 1'b0;
            pins_owned            <= 1'b0;
            analog_enable         <= 1'b0;
        end else begin
            usb_clk_enable        <= operation_enable & ~suspend_request; // R4
            xcvr_low_power        <= ~operation_enable | suspend_request; // R4
            module_outputs_enable <= operation_enable; // R5
            pins_owned            <= operation_enable; // R5
            analog_enable         <= operation_enable; // R5
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign irq_events = {prev_not_ready & ~module_not_ready,
                         activity_seen & ~bus_activity_pending};
    assign irq_clear  = (do_write && aw_addr == `UPS_OFF_IRQ_STATUS && w_strb[0]) ?
                        w_data[`UPS_IRQ_WIDTH-1:0] : `UPS_IRQ_RESET;

    always @(posedge clk) begin
        if (srst) begin
            irq_status     <= `UPS_IRQ_RESET;
            irq_mask       <= `UPS_IRQ_RESET;
            prev_not_ready <= 1'b0;
        end else begin
            prev_not_ready <= module_not_ready;
            irq_status     <= (irq_status & ~irq_clear) | irq_events;
            if (do_write && aw_addr == `UPS_OFF_IRQ_MASK && w_strb[0]) begin
                irq_mask <= w_data[`UPS_IRQ_WIDTH-1:0];
            end
        end
    end
    assign irq = |(irq_status & irq_mask);
endmodule // ups_power_ctrl

// ---- bench/ups_checker.sv ----
// Assertion checker for the USB power and suspend control block
`timescale 1ns/1ns
module ups_checker (
    input wire        clk,
    input wire        srst,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        sleep_request,
    input wire        sleep_block,
    input wire        usb_clk_enable,
    input wire        xcvr_low_power,
    input wire        module_outputs_enable,
    input wire        pins_owned,
    input wire        analog_enable,
    input wire        irq
);
// ----
// Properties
// ----
default clocking @(posedge clk); endclocking
default disable iff (srst);
a_gate_lowpwr: assert property (usb_clk_enable == !xcvr_low_power)
    else $error("clock gate and low power disagree");
a_gate_needs_en: assert property (usb_clk_enable |-> module_outputs_enable)
    else $error("usb clock runs while module off");
a_off_group: assert property (module_outputs_enable == pins_owned && pins_owned == analog_enable)
    else $error("enable group split");
a_block_needs_req: assert property (sleep_block |-> sleep_request)
    else $error("sleep refused without request");
a_unimpl_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hffffff64) == 32'h0)
    else $error("unimplemented bit read as one");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
a_reset_clear: assert property (disable iff (1'b0) srst |=> !module_outputs_enable && xcvr_low_power && !irq)
    else $error("outputs not cleared by reset");
c_sleep_block: cover property (sleep_block);
c_irq: cover property (irq);
c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // ups_checker
bind ups_power_ctrl ups_checker u_chk (.clk(clk), .srst(srst), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .sleep_request(sleep_request), .sleep_block(sleep_block), .usb_clk_enable(usb_clk_enable),
    .xcvr_low_power(xcvr_low_power), .module_outputs_enable(module_outputs_enable),
    .pins_owned(pins_owned), .analog_enable(analog_enable), .irq(irq));

// ---- bench/ups_usb_partner.sv ----
// Model of the USB bus side: activity, notifications and core activity
`timescale 1ns/1ns
module ups_usb_partner (
    input  wire  clk,
    input  wire  burst,
    input  wire  notify_req,
    input  wire  active_req,
    output logic bus_activity,
    output logic notify_done,
    output logic module_active
);
logic nq;
initial begin
    bus_activity = 0;
    notify_done = 0;
    module_active = 0;
    nq = 0;
end
// Bus activity is unrelated to the bus clock, so it lands off the edge
always @(burst) bus_activity <= #3 burst;
always @(posedge clk) begin
    nq <= notify_req;
    notify_done <= notify_req & ~nq;
    module_active <= active_req;
end
endmodule // ups_usb_partner

// ---- bench/ups_power_ctrl_test.sv ----
// Self-checking testbench for the USB power and suspend control block
`timescale 1ns/1ns
`include "ups_map.vh"
module ups_power_ctrl_test;
logic        clk = 0, srst = 1, act = 0, ntf = 0, busy_req = 0, slp = 0;
logic [3:0]  awaddr = 0, araddr = 0, wstrb = 0, ws = 4'hf;
logic [31:0] wdata = 0, rdata, d, e, seed = 32'h96ec9de7;
logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic        awready, wready, bvalid, arready, rvalid, sleep_block, irq;
logic        bus_activity, notify_done, module_active, clk_en, lowpwr, outs_en, pins, analog;
logic [1:0]  bresp, rresp, r;
integer      miscompares = 0, n_tests = 0, cyc = 0, i;
always #5 clk = ~clk;
ups_power_ctrl #(.SETTLE_CYCLES(2)) uut (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus_activity(bus_activity), .notify_done(notify_done),
    .module_active(module_active), .sleep_request(slp), .sleep_block(sleep_block),
    .usb_clk_enable(clk_en), .xcvr_low_power(lowpwr), .module_outputs_enable(outs_en),
    .pins_owned(pins), .analog_enable(analog), .irq(irq));
ups_usb_partner far (.clk(clk), .burst(act), .notify_req(ntf), .active_req(busy_req),
    .bus_activity(bus_activity), .notify_done(notify_done), .module_active(module_active));
// ----
// Tasks
// ----
function automatic [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
endfunction
task test_done;
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
        miscompares++;
        $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
endtask
// Handshakes are judged at the falling edge, where every level has settled
task wr(input [3:0] a, input [31:0] v);
    logic ha, hw, hb;
    awaddr <= a;
    wdata <= v;
    wstrb <= ws;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    hb = 0;
    while (!hb) begin
        @(negedge clk);
        ha = awvalid && awready;
        hw = wvalid && wready;
        hb = bvalid;
        r = bresp;
        @(posedge clk);
        if (ha) awvalid <= 0;
        if (hw) wvalid <= 0;
    end
    // One idle edge so a following call never re-raises bready in this step
    bready <= 0;
    @(posedge clk);
endtask
task rd(input [3:0] a);
    logic ha, hr;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    hr = 0;
    while (!hr) begin
        @(negedge clk);
        ha = arvalid && arready;
        hr = rvalid;
        d = rdata;
        r = rresp;
        @(posedge clk);
        if (ha) arvalid <= 0;
    end
    rready <= 0;
    @(posedge clk);
endtask
task chk_outs(input [31:0] c);
    @(negedge clk);
    chk_pin(clk_en, c[0] & ~c[1]);
    chk_pin(lowpwr, ~c[0] | c[1]);
    chk_pin(outs_en, c[0]);
    chk_pin(pins, c[0]);
    chk_pin(analog, c[0]);
    @(posedge clk);
endtask
task chk_at_fall(input logic exp_block, input logic exp_irq);
    @(negedge clk);
    chk_pin(sleep_block, exp_block);
    chk_pin(irq, exp_irq);
    @(posedge clk);
endtask
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
        miscompares++;
        test_done;
    end
end
// ----
// Scenarios
// ----
initial begin
    repeat (3) @(posedge clk);
    srst <= 0;
    rd(`UPS_OFF_POWER_CONTROL);
    chk(d, 32'h0);
    chk_outs(32'h0);
    for (i = 0; i < 8; i++) begin
        seed = xs(seed);
        wr(`UPS_OFF_POWER_CONTROL, seed);
        chk(r, `UPS_RESP_OKAY);
        e = seed & 32'h13;
        e[3] = e[0];
        repeat (4) @(posedge clk);
        rd(`UPS_OFF_POWER_CONTROL);
        chk(d, e);
        chk_outs(e);
    end
    wr(4'hc, 32'h13);
    chk(r, `UPS_RESP_SLVERR);
    rd(4'hc);
    chk(r, `UPS_RESP_SLVERR);
    chk(d, 32'h0);
    wr(`UPS_OFF_POWER_CONTROL, 32'h11);
    wr(`UPS_OFF_IRQ_MASK, 32'h1);
    wr(`UPS_OFF_IRQ_STATUS, 32'h3);
    act <= 1;
    slp <= 1;
    repeat (6) @(posedge clk);
    act <= 0;
    repeat (4) @(posedge clk);
    rd(`UPS_OFF_POWER_CONTROL);
    chk(d, 32'h99);
    chk_at_fall(1'b1, 1'b1);
    wr(`UPS_OFF_POWER_CONTROL, 32'h1);
    chk_at_fall(1'b0, 1'b1);
    ntf <= 1;
    wr(`UPS_OFF_POWER_CONTROL, 32'h11);
    ntf <= 0;
    // Low byte strobe off: the write is ignored but still answered
    ws = 4'he;
    wr(`UPS_OFF_POWER_CONTROL, 32'h0);
    ws = 4'hf;
    chk(r, `UPS_RESP_OKAY);
    rd(`UPS_OFF_POWER_CONTROL);
    chk(d, 32'h19);
    wr(`UPS_OFF_IRQ_STATUS, 32'h1);
    chk_at_fall(1'b0, 1'b0);
    wr(`UPS_OFF_POWER_CONTROL, 32'h0);
    busy_req <= 1;
    repeat (6) @(posedge clk);
    rd(`UPS_OFF_POWER_CONTROL);
    chk(d, 32'h8);
    busy_req <= 0;
    repeat (6) @(posedge clk);
    rd(`UPS_OFF_POWER_CONTROL);
    chk(d, 32'h0);
    rd(`UPS_OFF_IRQ_STATUS);
    chk(d, 32'h2);
    chk_at_fall(1'b0, 1'b0);
    wr(`UPS_OFF_IRQ_MASK, 32'h3);
    chk_at_fall(1'b0, 1'b1);
    wr(`UPS_OFF_IRQ_STATUS, 32'h2);
    chk_at_fall(1'b0, 1'b0);
    test_done;
end
endmodule // ups_power_ctrl_test
